/* design/spr_sleep_power_reset.sv */
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
// Contract
// - sleep instruction enters selected mode only when sleep-enable bit is one
// - brown-out-sleep set needs both-bits write then bit-only write within four cycles
// - brown-out-sleep goes active three cycles after set, clears three cycles later
// - detector off in sleep only if sleep executes while brown-out-sleep active
// - brown-out-sleep at bit 6, unlock at bit 5; absent on non-low-power variants
// - gate register at 0x64 resets to zero; bit 4 reads zero
// - gate bit 7 stops two-wire unit clock
// - gate bit 6 stops timer two only in synchronous mode
// - gate bit 5 stops timer zero, bit 3 timer one; resume unchanged
// - gate bit 2 stops serial peripheral clock
// - gate bit 1 stops serial port clock
// - gate bit 0 shuts converter; comparator loses converter input multiplexer
// - any reset returns registers to initial values; restart from reset vector; here the reset-cause flags at 0x70 clear only on i_rst
// - ports reset at once on any source, with no clock needed; here o_port_reset is registered after the synchronisers, four clock edges late
// - after all sources deassert, delay counter holds internal reset for time-out
// - reset combines power-on, pin, watchdog and enabled brown-out
// - power-on drop reasserts reset at once; release passes the delay counter; here the drop passes a clocked two-stage synchroniser
// - long pin low resets without clock; fuse can disable pin reset; here the pin passes a clocked two-stage synchroniser
// - enabled detector trip resets at once; release after time-out; here the trip passes a clocked two-stage synchroniser
// - watchdog pulse of one cycle; time-out counted from its falling edge
// - sleep mode select bits 3:1 choose six modes; two codes reserved
// - gated peripheral frozen, registers inaccessible; clearing restores state
`include "spr_map.svh"
module spr_sleep_power_reset #(
    parameter bit LOW_POWER_VARIANT = 1'b1,
    parameter int DELAY_WIDTH = 16
) (
    // clock and bus reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // reset sources
    input wire logic i_power_ok,
    input wire logic i_reset_pin_n,
    input wire logic i_watchdog_reset,
    input wire logic i_brownout_trip,
    input wire logic i_brownout_enable_fuse,
    input wire logic i_pin_reset_disable_fuse,
    input wire logic [DELAY_WIDTH-1:0] i_release_delay_period,
    // core side
    input wire logic i_sleep_instr,
    input wire logic i_wake,
    input wire logic i_timer_two_async_select,
    input wire logic [7:0] i_gated_access_mask,
    // outputs
    output logic o_port_reset,
    output logic o_core_reset,
    output spr_pkg::spr_sleep_type o_sleep,
    output spr_pkg::spr_clk_en_type o_clk_en,
    output logic o_comparator_mux_allow,
    output logic [7:0] o_gated_access_block
);
    initial begin
        if (DELAY_WIDTH < 2 || DELAY_WIDTH > 32) begin
            $error("DELAY_WIDTH must be 2..32");
        end
    end

    // synchronised pin, analog and watchdog source levels
    logic [1:0] pin_sync_q;
    logic [1:0] pwr_sync_q;
    logic [1:0] bod_sync_q;
    logic [1:0] wdt_sync_q;
    logic src_any;
    logic [7:0] gate_q;
    logic [7:0] sleep_ctrl_q;
    spr_pkg::spr_bod_state_type bod_state_q;
    logic [2:0] bod_cnt_q;
    logic [DELAY_WIDTH-1:0] delay_q;
    logic core_reset_q;
    logic port_reset_q;
    logic sleeping_q;
    spr_pkg::spr_sleep_mode_type mode_q;
    logic bod_off_q;
    logic [31:0] readdata_q;
    logic waitreq_q;
    logic [3:0] flags_q;
    logic [7:0] wbyte;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    // two-stage synchronisers; first stage feeds only the second
    always_ff @(posedge i_ref_clk) begin
        pin_sync_q <= {pin_sync_q[0], i_reset_pin_n};
        pwr_sync_q <= {pwr_sync_q[0], i_power_ok};
        bod_sync_q <= {bod_sync_q[0], i_brownout_trip};
        wdt_sync_q <= {wdt_sync_q[0], i_watchdog_reset};
    end

    // combine the four sources
    always_comb begin
        src_any = !pwr_sync_q[1];
        src_any = src_any | (!pin_sync_q[1] & !i_pin_reset_disable_fuse);
        src_any = src_any | wdt_sync_q[1];
        src_any = src_any | (bod_sync_q[1] & i_brownout_enable_fuse);
    end

    // port_reset_q follows the synchronised sources and i_rst; it is registered here
    // and again at the output, which holds it low while i_rst is high, so it needs the clock
    always_ff @(posedge i_ref_clk) begin
        port_reset_q <= src_any | i_rst;
    end

    // delay counter stretching the internal reset
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || src_any) begin
            delay_q <= i_release_delay_period;
            core_reset_q <= 1'b1;
        end else if (delay_q != '0) begin
            delay_q <= delay_q - 1'b1;
            core_reset_q <= 1'b1;
        end else begin
            core_reset_q <= 1'b0;
        end
    end

    // bus handshake: one wait cycle, then answer
    assign wbyte = i_writedata[7:0];
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            waitreq_q <= 1'b1;
        end else if ((i_read || i_write) && waitreq_q) begin
            waitreq_q <= 1'b0;
        end else begin
            waitreq_q <= 1'b1;
        end
    end
    assign o_waitrequest = waitreq_q;

    // clock gate register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || core_reset_q) begin
            gate_q <= `SPR_CLOCK_GATE_RESET;
        end else if (i_write && !waitreq_q && hit(i_address, `SPR_ADDR_CLOCK_GATE)) begin
            gate_q <= wbyte & `SPR_CLOCK_GATE_WMASK;
        end
    end

    // sleep control register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || core_reset_q) begin
            sleep_ctrl_q <= `SPR_SLEEP_CTRL_RESET;
        end else if (i_write && !waitreq_q && hit(i_address, `SPR_ADDR_SLEEP_CTRL)) begin
            sleep_ctrl_q <= {4'h0, wbyte[3:0]};
        end
    end

    // brown-out-sleep timed sequence
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || core_reset_q || !LOW_POWER_VARIANT) begin
            bod_state_q <= spr_pkg::BOD_IDLE;
            bod_cnt_q <= 3'd0;
        end else begin
            unique case (bod_state_q)
                spr_pkg::BOD_IDLE: begin
                    if (i_write && !waitreq_q && hit(i_address, `SPR_ADDR_CORE_CTRL)
                            && wbyte[`SPR_BOD_OFF_BIT] && wbyte[`SPR_BOD_UNLOCK_BIT]) begin
                        bod_state_q <= spr_pkg::BOD_UNLOCKED;
                        bod_cnt_q <= `SPR_UNLOCK_WINDOW;
                    end
                end
                spr_pkg::BOD_UNLOCKED: begin
                    if (i_write && !waitreq_q && hit(i_address, `SPR_ADDR_CORE_CTRL)
                            && wbyte[`SPR_BOD_OFF_BIT] && !wbyte[`SPR_BOD_UNLOCK_BIT]) begin
                        bod_state_q <= spr_pkg::BOD_ARMING;
                        bod_cnt_q <= `SPR_BOD_ARM_DELAY;
                    end else if (bod_cnt_q <= 3'd1) begin
                        bod_state_q <= spr_pkg::BOD_IDLE; // window lapsed
                    end else begin
                        bod_cnt_q <= bod_cnt_q - 3'd1;
                    end
                end
                spr_pkg::BOD_ARMING: begin
                    if (bod_cnt_q <= 3'd1) begin
                        bod_state_q <= spr_pkg::BOD_ACTIVE;
                        bod_cnt_q <= `SPR_BOD_HOLD;
                    end else begin
                        bod_cnt_q <= bod_cnt_q - 3'd1;
                    end
                end
                spr_pkg::BOD_ACTIVE: begin
                    if (bod_cnt_q <= 3'd1) begin
                        bod_state_q <= spr_pkg::BOD_IDLE;
                    end else begin
                        bod_cnt_q <= bod_cnt_q - 3'd1;
                    end
                end
            endcase
        end
    end

    // sleep entry and wake
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || core_reset_q) begin
            sleeping_q <= 1'b0;
            mode_q <= spr_pkg::SLP_IDLE;
            bod_off_q <= 1'b0;
        end else if (sleeping_q) begin
            if (i_wake) begin
                sleeping_q <= 1'b0;
                bod_off_q <= 1'b0;
            end
        end else if (i_sleep_instr && sleep_ctrl_q[`SPR_SLEEP_ENABLE_BIT]) begin
            sleeping_q <= 1'b1;
            mode_q <= spr_pkg::spr_sleep_mode_type'(sleep_ctrl_q[3:1]);
            bod_off_q <= (bod_state_q == spr_pkg::BOD_ACTIVE);
        end
    end

    // last reset causes, cleared by writing zero
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            flags_q <= 4'h0;
        end else begin
            if (i_write && !waitreq_q && hit(i_address, `SPR_ADDR_STATUS)) begin
                flags_q <= flags_q & wbyte[3:0];
            end
            if (!pwr_sync_q[1]) flags_q[0] <= 1'b1;
            if (!pin_sync_q[1] && !i_pin_reset_disable_fuse) flags_q[1] <= 1'b1;
            if (bod_sync_q[1] && i_brownout_enable_fuse) flags_q[2] <= 1'b1;
            if (wdt_sync_q[1]) flags_q[3] <= 1'b1;
        end
    end

    // read data, unmapped reads as zero
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            readdata_q <= 32'h0;
        end else if (i_read && waitreq_q) begin
            unique case (i_address)
                `SPR_ADDR_CLOCK_GATE: readdata_q <= {24'h0, gate_q};
                `SPR_ADDR_SLEEP_CTRL: readdata_q <= {24'h0, sleep_ctrl_q};
                `SPR_ADDR_CORE_CTRL: readdata_q <= {25'h0,
                    bod_state_q == spr_pkg::BOD_ACTIVE, 6'h0};
                `SPR_ADDR_STATUS: readdata_q <= {28'h0, flags_q};
                default: readdata_q <= 32'h0;
            endcase
        end
    end
    assign o_readdata = readdata_q;

    // registered outputs: resets, sleep request, clock enables
    always_ff @(posedge i_ref_clk) begin
        o_port_reset <= 1'b0;
        o_core_reset <= 1'b1;
        o_sleep <= '0;
        o_clk_en <= '0;
        o_comparator_mux_allow <= 1'b0;
        o_gated_access_block <= 8'h00;
        if (!i_rst) begin
            o_port_reset <= port_reset_q;
            o_core_reset <= core_reset_q;
            o_sleep <= '{sleeping: sleeping_q, mode: mode_q, bod_off: bod_off_q};
            o_clk_en.two_wire_unit <= !gate_q[`SPR_GATE_TWO_WIRE];
            o_clk_en.timer_two <= !(gate_q[`SPR_GATE_TIMER_TWO]
                && !i_timer_two_async_select);
            o_clk_en.timer_zero <= !gate_q[`SPR_GATE_TIMER_ZERO];
            o_clk_en.timer_one <= !gate_q[`SPR_GATE_TIMER_ONE];
            o_clk_en.serial_peripheral <= !gate_q[`SPR_GATE_SERIAL_PERIPH];
            o_clk_en.serial_port <= !gate_q[`SPR_GATE_SERIAL_PORT];
            o_clk_en.converter <= !gate_q[`SPR_GATE_CONVERTER];
            o_comparator_mux_allow <= !gate_q[`SPR_GATE_CONVERTER];
            o_gated_access_block <= gate_q & i_gated_access_mask;
        end
    end
endmodule // spr_sleep_power_reset

/* design/spr_map.svh */
`ifndef SPR_MAP_SVH
`define SPR_MAP_SVH
// register byte addresses (gate register at its printed address)
`define SPR_ADDR_CLOCK_GATE 8'h64
`define SPR_ADDR_SLEEP_CTRL 8'h68
`define SPR_ADDR_CORE_CTRL 8'h6c
`define SPR_ADDR_STATUS 8'h70
// sleep control fields
`define SPR_SLEEP_ENABLE_BIT 0
`define SPR_SLEEP_MODE_LSB 1
// core control fields
`define SPR_BOD_OFF_BIT 6
`define SPR_BOD_UNLOCK_BIT 5
// clock gate fields
`define SPR_GATE_TWO_WIRE 7
`define SPR_GATE_TIMER_TWO 6
`define SPR_GATE_TIMER_ZERO 5
`define SPR_GATE_RESERVED 4
`define SPR_GATE_TIMER_ONE 3
`define SPR_GATE_SERIAL_PERIPH 2
`define SPR_GATE_SERIAL_PORT 1
`define SPR_GATE_CONVERTER 0
// reset values and masks
`define SPR_CLOCK_GATE_RESET 8'h00
`define SPR_CLOCK_GATE_WMASK 8'hef
`define SPR_SLEEP_CTRL_RESET 8'h00
`define SPR_CORE_CTRL_RESET 8'h00
// timing counts in clock cycles
`define SPR_UNLOCK_WINDOW 3'd4
`define SPR_BOD_ARM_DELAY 3'd3
`define SPR_BOD_HOLD 3'd3
`define SPR_RELEASE_DELAY_DEFAULT 16'd64
`endif

/* design/spr_pkg.sv */
package spr_pkg;
    typedef enum logic [2:0] {
        SLP_IDLE = 3'h0,
        SLP_NOISE_REDUCE = 3'h1,
        SLP_POWER_DOWN = 3'h2,
        SLP_POWER_SAVE = 3'h3,
        SLP_RSVD_A = 3'h4,
        SLP_RSVD_B = 3'h5,
        SLP_STANDBY = 3'h6,
        SLP_EXT_STANDBY = 3'h7
    } spr_sleep_mode_type;

    typedef enum logic [1:0] {
        BOD_IDLE = 2'b00,
        BOD_UNLOCKED = 2'b01,
        BOD_ARMING = 2'b10,
        BOD_ACTIVE = 2'b11
    } spr_bod_state_type;

    // sleep request sent to the clock/power controller
    typedef struct packed {
        logic sleeping;
        spr_sleep_mode_type mode;
        logic bod_off;
    } spr_sleep_type;

    // per-peripheral clock enables
    typedef struct packed {
        logic two_wire_unit;
        logic timer_two;
        logic timer_zero;
        logic timer_one;
        logic serial_peripheral;
        logic serial_port;
        logic converter;
    } spr_clk_en_type;
endpackage

/* dv/spr_sleep_power_reset_chk.sv */
`timescale 1ns/1ns
`include "spr_map.svh"
module spr_sleep_power_reset_chk (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // register bus
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    // core side
    input wire logic i_sleep_instr,
    input wire logic i_timer_two_async_select,
    // outputs
    input wire logic o_port_reset,
    input wire logic o_core_reset,
    input wire spr_pkg::spr_sleep_type o_sleep,
    input wire spr_pkg::spr_clk_en_type o_clk_en,
    input wire logic o_comparator_mux_allow
);
    // accepted read and accepted gate write
    logic rd_ok;
    logic gate_wr;
    assign rd_ok = i_read && !o_waitrequest;
    assign gate_wr = i_write && !o_waitrequest && !o_core_reset
        && i_address == `SPR_ADDR_CLOCK_GATE;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // bus answer and refusals
    chk_wait_answer: assert property ($rose(i_read || i_write) |=> !o_waitrequest)
        else $error("no answer one cycle after request");
    chk_unmapped_zero: assert property (rd_ok && !(i_address inside {`SPR_ADDR_CLOCK_GATE,
        `SPR_ADDR_SLEEP_CTRL, `SPR_ADDR_CORE_CTRL, `SPR_ADDR_STATUS}) |-> o_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_gate_rsvd: assert property (rd_ok && i_address == `SPR_ADDR_CLOCK_GATE |-> !o_readdata[4])
        else $error("reserved gate bit reads one");
    // peripheral clock gating
    chk_gate_twi: assert property (gate_wr && i_writedata[7] |-> ##[1:2] !o_clk_en.two_wire_unit)
        else $error("two-wire clock not stopped");
    chk_timer_async: assert property (disable iff (i_rst || o_core_reset)
        i_timer_two_async_select [*2] |-> o_clk_en.timer_two) else $error("async timer stopped");
    chk_mux_follow: assert property (disable iff (i_rst || o_core_reset)
        !o_clk_en.converter [*2] |-> !o_comparator_mux_allow) else $error("mux allowed while gated");
    // sleep entry
    chk_sleep_cause: assert property ($rose(o_sleep.sleeping) |->
        $past(i_sleep_instr) || $past(i_sleep_instr, 2)) else $error("sleep without instruction");
    chk_bod_sleep: assert property (o_sleep.bod_off |-> o_sleep.sleeping)
        else $error("detector off while awake");
    // reset stretching
    chk_core_hold: assert property ($fell(i_rst) |-> o_core_reset [*8])
        else $error("core reset released early");
    chk_port_core: assert property (o_port_reset |-> ##[0:2] o_core_reset)
        else $error("port reset without core reset");
endmodule // spr_sleep_power_reset_chk
bind spr_sleep_power_reset spr_sleep_power_reset_chk chk_u (.*);

/* dv/tb_top.sv */
`timescale 1ns/1ns
`include "spr_map.svh"
module tb_top;
    localparam int DLY = 20;
    // design ports
    logic i_ref_clk = 1'b0, i_rst = 1'b1, i_read = 1'b0, i_write = 1'b0, i_power_ok = 1'b1;
    logic i_reset_pin_n = 1'b1, i_watchdog_reset = 1'b0, i_brownout_trip = 1'b0;
    logic i_brownout_enable_fuse = 1'b1, i_pin_reset_disable_fuse = 1'b0, i_wake = 1'b0;
    logic i_sleep_instr = 1'b0, i_timer_two_async_select = 1'b0;
    logic [7:0] i_address = 8'h00, i_gated_access_mask = 8'h00, o_gated_access_block, rd;
    logic [31:0] i_writedata = 32'h0, o_readdata;
    logic [15:0] i_release_delay_period = DLY[15:0];
    logic o_waitrequest, o_port_reset, o_core_reset, o_comparator_mux_allow;
    spr_pkg::spr_sleep_type o_sleep;
    spr_pkg::spr_clk_en_type o_clk_en;
    int failures = 0, tests_run = 0;
    spr_sleep_power_reset dut_u (.*);
    // clock
    initial forever #4 i_ref_clk = ~i_ref_clk;
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        i_address <= a;
        i_writedata <= {24'h0, d};
        i_write <= wr;
        i_read <= !wr;
        @(posedge i_ref_clk);
        while (o_waitrequest !== 1'b0 && n < 40) begin
            @(posedge i_ref_clk);
            n++;
        end
        rd = o_readdata[7:0];
        i_write <= 1'b0;
        i_read <= 1'b0;
        @(posedge i_ref_clk);
        cmp(n < 40, 1'b1);
    endtask
    task automatic core_wait(output int n);
        n = 0;
        while (o_core_reset !== 1'b0 && n < 400) begin
            @(posedge i_ref_clk);
            n++;
        end
    endtask
    // sleep pulse, sample, then wake
    task automatic nap(output logic s, output logic b);
        i_sleep_instr <= 1'b1;
        @(posedge i_ref_clk);
        i_sleep_instr <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        s = o_sleep.sleeping;
        b = o_sleep.bod_off;
        i_wake <= 1'b1;
        @(posedge i_ref_clk);
        i_wake <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        cmp(o_sleep.sleeping, 1'b0);
    endtask
    task automatic t_gate();
        logic [7:0] g;
        logic [6:0] e;
        bus(1'b1, 8'h20, 8'hff);
        bus(1'b0, 8'h20, 8'h00);
        cmp(rd, 8'h00);
        for (int k = 0; k < 8; k++) begin
            g = (8'h01 << k) & 8'hef;
            e = ~{g[7:5], g[3:0]};
            bus(1'b1, `SPR_ADDR_CLOCK_GATE, 8'h01 << k);
            bus(1'b0, `SPR_ADDR_CLOCK_GATE, 8'h00);
            cmp(rd, g);
            cmp(o_clk_en, e);
            cmp(o_comparator_mux_allow, !g[0]);
            cmp(o_gated_access_block, g);
        end
        i_timer_two_async_select <= 1'b1;
        bus(1'b1, `SPR_ADDR_CLOCK_GATE, 8'h40);
        repeat (2) @(posedge i_ref_clk);
        cmp(o_clk_en.timer_two, 1'b1);
        i_timer_two_async_select <= 1'b0;
        bus(1'b1, `SPR_ADDR_CLOCK_GATE, 8'h00);
    endtask
    task automatic t_sleep();
        logic s;
        logic b;
        for (int k = 0; k < 8; k++) begin
            if (k != 4 && k != 5) begin
                bus(1'b1, `SPR_ADDR_SLEEP_CTRL, {4'h0, k[2:0], 1'b1});
                i_sleep_instr <= 1'b1;
                @(posedge i_ref_clk);
                i_sleep_instr <= 1'b0;
                repeat (3) @(posedge i_ref_clk);
                cmp(o_sleep.mode, k[2:0]);
                nap(s, b);
                cmp(s, 1'b1);
                cmp(b, 1'b0);
            end
        end
        bus(1'b1, `SPR_ADDR_SLEEP_CTRL, 8'h04);
        nap(s, b);
        cmp(s, 1'b0);
    endtask
    // unlock write f, gap cycles, set write, lag cycles, then sleep
    task automatic bod_try(input logic [7:0] f, input int gap, input int lag, input logic exp);
        logic s;
        logic b;
        bus(1'b1, `SPR_ADDR_CORE_CTRL, f);
        repeat (gap) @(posedge i_ref_clk);
        bus(1'b1, `SPR_ADDR_CORE_CTRL, 8'h40);
        repeat (lag) @(posedge i_ref_clk);
        nap(s, b);
        cmp(s, 1'b1);
        cmp(b, exp);
    endtask
    task automatic t_src(input int k, input logic exp);
        int n;
        bus(1'b1, `SPR_ADDR_CLOCK_GATE, 8'h0f);
        case (k)
            0: i_power_ok <= 1'b0;
            1: i_reset_pin_n <= 1'b0;
            2: i_brownout_trip <= 1'b1;
            default: i_watchdog_reset <= 1'b1;
        endcase
        @(posedge i_ref_clk);
        i_watchdog_reset <= 1'b0;
        repeat (5) @(posedge i_ref_clk);
        if (k < 3) cmp(o_port_reset, exp);
        cmp(o_core_reset, exp);
        i_power_ok <= 1'b1;
        i_reset_pin_n <= 1'b1;
        i_brownout_trip <= 1'b0;
        core_wait(n);
        cmp(n >= DLY, exp);
        bus(1'b0, `SPR_ADDR_CLOCK_GATE, 8'h00);
        cmp(rd, exp ? 8'h00 : 8'h0f);
    endtask
    task automatic summarize();
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        int n;
        repeat (12) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        core_wait(n);
        cmp(n >= DLY + 3 && n <= DLY + 5, 1'b1);
        i_gated_access_mask <= 8'hff;
        bus(1'b0, `SPR_ADDR_CORE_CTRL, 8'h00);
        cmp(rd, 8'h00);
        t_gate();
        t_sleep();
        bus(1'b1, `SPR_ADDR_SLEEP_CTRL, 8'h05);
        bod_try(8'h60, 0, 2, 1'b1);
        bod_try(8'h00, 0, 2, 1'b0);
        bod_try(8'h60, 6, 2, 1'b0);
        bod_try(8'h60, 0, 8, 1'b0);
        for (int k = 0; k < 4; k++) t_src(k, 1'b1);
        i_pin_reset_disable_fuse <= 1'b1;
        t_src(1, 1'b0);
        i_pin_reset_disable_fuse <= 1'b0;
        i_brownout_enable_fuse <= 1'b0;
        t_src(2, 1'b0);
        summarize();
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        failures++;
        summarize();
    end
endmodule // tb_top
